// ---- rtl/asc_pkg.sv ----
// Purpose: Constants shared by the converter sequencer and its bench.
// Assumes: Byte-wide register port, 10-bit byte addresses.
// Notes:   Field positions and reset values of the control bytes.
package asc_pkg;
   // ****************************************************
   // Register addresses
   // ****************************************************
   localparam logic [9:0] ASC_ADDR_CTRL0    = 10'h3D6;
   localparam logic [9:0] ASC_ADDR_CTRL1    = 10'h3D7;
   localparam logic [9:0] ASC_ADDR_CTRL2    = 10'h3D4;
   localparam logic [9:0] ASC_ADDR_RES_BASE = 10'h3C0;
   localparam logic [9:0] ASC_ADDR_RES_LAST = 10'h3CF;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int ASC_C0_CHAN_LSB  = 0;   // Single channel select, 3 bits
   localparam int ASC_C0_MODE_LSB  = 3;   // Operating mode, 3 bits
   localparam int ASC_C0_START_BIT = 6;   // Conversion start flag
   localparam int ASC_C1_GRP_LSB   = 0;   // Sweep group select, 2 bits
   localparam int ASC_C1_RES10_BIT = 2;   // 1: 10-bit result
   localparam int ASC_C1_DIV_LSB   = 3;   // Clock divider select, 2 bits
   localparam int ASC_C1_VREF_BIT  = 5;   // Ladder connected to reference
   localparam int ASC_C1_SEC_BIT   = 6;   // Secondary input group
   localparam int ASC_C2_SH_BIT    = 0;   // Sample-and-hold enable

   // ****************************************************
   // Reset values
   // ****************************************************
   localparam logic [7:0] ASC_CTRL0_RST = 8'h00;
   localparam logic [7:0] ASC_CTRL1_RST = 8'h00;
   localparam logic [7:0] ASC_CTRL2_RST = 8'h00;

   // ****************************************************
   // Mode and divider codes
   // ****************************************************
   localparam logic [2:0] ASC_MODE_ONESHOT = 3'h0;
   localparam logic [2:0] ASC_MODE_REPEAT  = 3'h1;
   localparam logic [2:0] ASC_MODE_SWEEP   = 3'h2;
   localparam logic [2:0] ASC_MODE_RSWEEP0 = 3'h3;
   localparam logic [2:0] ASC_MODE_RSWEEP1 = 3'h4;
   localparam logic [1:0] ASC_DIV_1        = 2'h0;
   localparam logic [1:0] ASC_DIV_2        = 2'h1;
   localparam logic [1:0] ASC_DIV_LIM_1    = 2'h0;
   localparam logic [1:0] ASC_DIV_LIM_2    = 2'h1;
   localparam logic [1:0] ASC_DIV_LIM_4    = 2'h3;

   // ****************************************************
   // Conversion lengths in converter clock cycles, code reset value and MSB position
   // ****************************************************
   localparam logic [5:0] ASC_CYC_8       = 6'd49;
   localparam logic [5:0] ASC_CYC_10      = 6'd59;
   localparam logic [5:0] ASC_CYC_8_SH    = 6'd28;
   localparam logic [5:0] ASC_CYC_10_SH   = 6'd33;
   localparam logic [5:0] ASC_TRIALS_8    = 6'd16;  // Two cycles per bit
   localparam logic [5:0] ASC_TRIALS_10   = 6'd20;
   localparam logic [9:0] ASC_CODE_RST    = 10'h000;
   localparam logic [3:0] ASC_MSB_POS     = 4'h9;
endpackage

// ---- rtl/asc_sequencer.sv ----
// Purpose: Sequencer and successive-approximation control of the converter.
// Assumes: CLK_IN is the converter source clock; comparator is an async pin.
// Notes:   Byte register port, read data one cycle after the read strobe.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
// Function
// R1: One shared 10-bit SAR core, result resolution 8 or 10 bits by software.
// R2: Software sets every analog pin to input before converting it.
// R3: Reference bit 5 of control byte connects the ladder; set before starting.
// R4: 10-bit result: low 8 bits to even byte, top 2 to odd byte.
// R5: 8-bit result goes only into the even byte of the channel.
// R6: Conversion clock is source clock divided by 1, 2 or 4.
// R7: Conversion starts only when software turns the start flag to one.
// R8: Without sample-and-hold a channel takes 49 or 59 cycles.
// R9: With sample-and-hold a channel takes 28 or 33 cycles.
// R10: Software keeps converter clock at least 250 kHz, or 1 MHz with hold.
// R11: Five modes: one-shot, repeat, single sweep, repeat sweep 0 and 1.
// R12: One-shot converts the selected channel once and stops.
// R13: One-shot and single sweep clear start flag and request interrupt at end.
// R14: Repeat converts the selected channel back to back, no interrupt.
// R15: One-shot and repeat may select any primary channel 0 to 7.
// R16: Single sweep converts group 0-1, 0-3, 0-5 or 0-7 once ascending.
// R17: Repeat sweep 0 cycles through the group forever, no interrupt.
// R18: Writing zero to the start flag stops every mode.
// R19: Result registers readable any time, each with latest channel result.
// R20: Secondary five inputs replace primary channels 0 to 4 in every mode.
// R21: Repeat sweep 1 sweeps all channels, emphasised ones between each other.
// R22: Sample-and-hold enabled by bit 0 of the second control byte; the code takes it from bit 0 of control byte 2.
// R23: Software fixes sample-and-hold before start, never changes it mid-run.
// R24: Each result overwrites its channel register at the end, no overrun flag.
module asc_sequencer
   import asc_pkg::*;
(
   input  wire logic       CLK_IN,
   input  wire logic       RST_N_IN,
   input  wire logic [9:0] ADDR_IN,
   input  wire logic [7:0] WR_DATA_IN,
   input  wire logic       WR_IN,
   input  wire logic       RD_IN,
   input  wire logic       COMPARE_IN,
   output logic      [7:0] RD_DATA_OUT,
   output logic      [2:0] CHAN_OUT,
   output logic            SECONDARY_OUT,
   output logic            SAMPLE_OUT,
   output logic      [9:0] TRIAL_CODE_OUT,
   output logic            LADDER_ON_OUT,
   output logic            BUSY_OUT,
   output logic            IRQ_OUT
);

   // ****************************************************
   // Declarations
   // ****************************************************
   typedef enum logic {ST_IDLE, ST_CONV} asc_state_t;

   asc_state_t  state;
   logic [7:0]  ctrl0;
   logic [7:0]  ctrl1;
   logic [7:0]  ctrl2;
   logic [7:0]  res_lo [8];
   logic [1:0]  res_hi [8];
   logic [1:0]  div_cnt;
   logic [1:0]  div_lim;
   logic        tick;
   logic [5:0]  cnt;
   logic [5:0]  conv_len;
   logic [5:0]  samp_len;
   logic [5:0]  phase;
   logic [3:0]  bit_pos;
   logic [9:0]  code;
   logic [9:0]  bit_mask;
   logic [9:0]  dec_code;
   logic        cmp_s1;
   logic        cmp_s2;
   logic        cmp_s3;
   logic        cmp_filt;
   logic        cmp_take;
   logic        sh_q;
   logic        res10_q;
   logic [2:0]  ch;
   logic        emph;
   logic [2:0]  other;
   logic [2:0]  next_ch;
   logic        next_emph;
   logic [2:0]  next_other;
   logic [2:0]  mode;
   logic [1:0]  grp;
   logic [2:0]  last_ch;
   logic [2:0]  emph_last;
   logic        wr_c0;
   logic        start_rise;
   logic        stop_req;
   logic        chan_end;
   logic        seq_done;
   logic        cfg_load;
   logic [7:0]  rd_mux;
   assign mode      = ctrl0[ASC_C0_MODE_LSB +: 3];
   assign grp       = ctrl1[ASC_C1_GRP_LSB +: 2];
   assign last_ch   = {grp, 1'b1};
   assign emph_last = {1'b0, grp};
   // ****************************************************
   // Start flag and control bytes
   // ****************************************************
   // Start edge and stop requests decoded from a write to control byte 0
   assign wr_c0      = WR_IN && (ADDR_IN == ASC_ADDR_CTRL0);
   assign start_rise = wr_c0 && WR_DATA_IN[ASC_C0_START_BIT] && !ctrl0[ASC_C0_START_BIT]; // R7
   assign stop_req   = wr_c0 && !WR_DATA_IN[ASC_C0_START_BIT]; // R18
   // Control byte 0; a software write wins over the hardware clear
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ctrl0 <= ASC_CTRL0_RST;
      end else if (wr_c0) begin
         ctrl0 <= {1'b0, WR_DATA_IN[6:0]};
      end else if (seq_done) begin
         ctrl0[ASC_C0_START_BIT] <= 1'b0; // R13
      end
   end
   // Control bytes 1 and 2
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ctrl1 <= ASC_CTRL1_RST;
         ctrl2 <= ASC_CTRL2_RST;
      end else if (WR_IN) begin
         if (ADDR_IN == ASC_ADDR_CTRL1) begin
            ctrl1 <= {1'b0, WR_DATA_IN[6:0]};
         end
         if (ADDR_IN == ASC_ADDR_CTRL2) begin
            ctrl2 <= {7'h00, WR_DATA_IN[ASC_C2_SH_BIT]}; // R22
         end
      end
   end
   // Ladder only connected while the reference bit is set
   assign LADDER_ON_OUT = ctrl1[ASC_C1_VREF_BIT]; // R3
   // ****************************************************
   // Conversion clock divider
   // ****************************************************
   always_comb begin
      case (ctrl1[ASC_C1_DIV_LSB +: 2])
         ASC_DIV_1: div_lim = ASC_DIV_LIM_1; // R6
         ASC_DIV_2: div_lim = ASC_DIV_LIM_2; // R6
         default:   div_lim = ASC_DIV_LIM_4; // R6
      endcase
   end
   // Divider restarts with every conversion run
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         div_cnt <= 2'h0;
      end else if (state == ST_IDLE || tick) begin
         div_cnt <= 2'h0;
      end else begin
         div_cnt <= div_cnt + 2'h1;
      end
   end
   assign tick = (state == ST_CONV) && (div_cnt >= div_lim);
   // ****************************************************
   // Comparator synchroniser
   // ****************************************************
   // Third stage guards the filter; value taken once stages two and three agree
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         cmp_s1   <= 1'b0;
         cmp_s2   <= 1'b0;
         cmp_s3   <= 1'b0;
         cmp_filt <= 1'b0;
      end else begin
         cmp_s1 <= COMPARE_IN;
         cmp_s2 <= cmp_s1;
         cmp_s3 <= cmp_s2;
         if (cmp_s2 == cmp_s3) begin
            cmp_filt <= cmp_s3;
         end
      end
   end
   // Agreed value used at once, so a decision four clocks after the trial sees it
   assign cmp_take = (cmp_s2 == cmp_s3) ? cmp_s3 : cmp_filt;

   // ****************************************************
   // Channel timing and bit trials
   // ****************************************************
   // Per-channel length from latched hold and resolution settings
   always_comb begin
      case ({sh_q, res10_q})
         2'b00:   conv_len = ASC_CYC_8;     // R8
         2'b01:   conv_len = ASC_CYC_10;    // R8
         2'b10:   conv_len = ASC_CYC_8_SH;  // R9
         default: conv_len = ASC_CYC_10_SH; // R9
      endcase
      samp_len = conv_len - (res10_q ? ASC_TRIALS_10 : ASC_TRIALS_8);
   end
   // Trial bit walks from the MSB down, two converter clocks per bit
   assign phase    = cnt - samp_len;
   assign bit_pos  = ASC_MSB_POS - phase[4:1];
   assign bit_mask = 10'h001 << bit_pos;
   assign dec_code = cmp_take ? (code & ~bit_mask) : code;
   assign chan_end = tick && (cnt == conv_len - 6'd1);
   assign cfg_load = start_rise || (chan_end && !seq_done);
   // Hold and resolution fixed for each channel conversion
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         sh_q    <= 1'b0;
         res10_q <= 1'b0;
      end else if (cfg_load) begin
         sh_q    <= ctrl2[ASC_C2_SH_BIT];    // R23
         res10_q <= ctrl1[ASC_C1_RES10_BIT]; // R1
      end
   end
   // Cycle counter within one channel conversion
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         cnt <= 6'd0;
      end else if (state == ST_IDLE || chan_end) begin
         cnt <= 6'd0;
      end else if (tick) begin
         cnt <= cnt + 6'd1;
      end
   end
   // Successive-approximation register: set on even, decide on odd phase
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         code <= ASC_CODE_RST;
      end else if (state == ST_IDLE || chan_end) begin
         code <= ASC_CODE_RST;
      end else if (tick && cnt >= samp_len) begin
         code <= phase[0] ? dec_code : (code | bit_mask); // R1
      end
   end
   // ****************************************************
   // Channel sequencing
   // ****************************************************
   // Next channel after the current one ends, per mode
   always_comb begin
      next_ch    = ch;
      next_emph  = emph;
      next_other = other;
      seq_done   = 1'b0;
      case (mode) // R11
         ASC_MODE_ONESHOT: begin
            seq_done = chan_end; // R12
         end
         ASC_MODE_REPEAT: begin
            next_ch = ctrl0[ASC_C0_CHAN_LSB +: 3]; // R14
         end
         ASC_MODE_SWEEP, ASC_MODE_RSWEEP0: begin
            if (ch == last_ch) begin
               next_ch  = 3'd0;                                  // R17
               seq_done = chan_end && (mode == ASC_MODE_SWEEP); // R16
            end else begin
               next_ch = ch + 3'd1; // R16
            end
         end
         ASC_MODE_RSWEEP1: begin
            if (!emph) begin
               next_ch    = 3'd0;
               next_emph  = 1'b1;
               next_other = (other == 3'd7) ? emph_last + 3'd1 : other + 3'd1; // R21
            end else if (ch == emph_last) begin
               next_ch   = other; // R21
               next_emph = 1'b0;
            end else begin
               next_ch = ch + 3'd1;
            end
         end
         default: begin
            seq_done = chan_end;
         end
      endcase
   end
   // Current channel and emphasis pointers
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ch    <= 3'd0;
         emph  <= 1'b1;
         other <= 3'd1;
      end else if (start_rise) begin
         ch    <= (WR_DATA_IN[ASC_C0_MODE_LSB +: 3] <= ASC_MODE_REPEAT) ?
                  WR_DATA_IN[ASC_C0_CHAN_LSB +: 3] : 3'd0; // R15
         emph  <= 1'b1;
         other <= emph_last + 3'd1;
      end else if (chan_end) begin
         ch    <= next_ch;
         emph  <= next_emph;
         other <= next_other;
      end
   end
   // Run state: start edge begins, zero write or sequence end stops
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_rise) begin
                  state <= ST_CONV; // R7
               end
            end
            ST_CONV: begin
               if (stop_req || seq_done) begin
                  state <= ST_IDLE; // R18
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
   // Completion request, one cycle, in one-shot, single sweep and the unused mode codes 5 to 7
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= seq_done && !stop_req; // R13
      end
   end
   // ****************************************************
   // Result registers
   // ****************************************************
   // Latest result overwrites the channel register, no overrun check
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         for (int i = 0; i < 8; i++) begin
            res_lo[i] <= 8'h00;
            res_hi[i] <= 2'h0;
         end
      end else if (chan_end && !stop_req) begin // R24
         if (res10_q) begin
            res_lo[ch] <= dec_code[7:0]; // R4
            res_hi[ch] <= dec_code[9:8]; // R4
         end else begin
            res_lo[ch] <= dec_code[9:2]; // R5
         end
      end
   end

   // ****************************************************
   // Read port
   // ****************************************************
   // Read mux; results readable at any time, unmapped reads zero
   always_comb begin
      rd_mux = 8'h00;
      if (ADDR_IN >= ASC_ADDR_RES_BASE && ADDR_IN <= ASC_ADDR_RES_LAST) begin
         rd_mux = ADDR_IN[0] ? {6'h00, res_hi[ADDR_IN[3:1]]} : res_lo[ADDR_IN[3:1]]; // R19
      end else if (ADDR_IN == ASC_ADDR_CTRL0) begin
         rd_mux = ctrl0;
      end else if (ADDR_IN == ASC_ADDR_CTRL1) begin
         rd_mux = ctrl1;
      end else if (ADDR_IN == ASC_ADDR_CTRL2) begin
         rd_mux = ctrl2;
      end
   end
   // Read data stands only in the cycle after the strobe
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         RD_DATA_OUT <= 8'h00;
      end else begin
         RD_DATA_OUT <= RD_IN ? rd_mux : 8'h00;
      end
   end
   // ****************************************************
   // Analog front end controls
   // ****************************************************
   assign CHAN_OUT       = ch;
   assign SECONDARY_OUT  = ctrl1[ASC_C1_SEC_BIT] && (ch <= 3'd4); // R20
   assign SAMPLE_OUT     = (state == ST_CONV) && (cnt < samp_len);
   assign TRIAL_CODE_OUT = code;
   assign BUSY_OUT       = (state == ST_CONV);
endmodule

// ---- verification/asc_sequencer_asserts.sv ----
// Purpose: Port checks of the converter sequencer.
// Assumes: One clock, async active-low reset.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ns
module asc_sequencer_asserts
   import asc_pkg::*;
(
   input wire logic       CLK_IN,
   input wire logic       RST_N_IN,
   input wire logic [9:0] ADDR_IN,
   input wire logic [7:0] WR_DATA_IN,
   input wire logic       WR_IN,
   input wire logic       RD_IN,
   input wire logic       COMPARE_IN,
   input wire logic [7:0] RD_DATA_OUT,
   input wire logic [2:0] CHAN_OUT,
   input wire logic       SECONDARY_OUT,
   input wire logic       SAMPLE_OUT,
   input wire logic [9:0] TRIAL_CODE_OUT,
   input wire logic       LADDER_ON_OUT,
   input wire logic       BUSY_OUT,
   input wire logic       IRQ_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   logic [2:0] mode;
   // Mode last written by software
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) mode <= ASC_MODE_ONESHOT;
      else if (WR_IN && ADDR_IN == ASC_ADDR_CTRL0) mode <= WR_DATA_IN[5:3];
   end
   // Control write, and a conversion ending without a stop write
   sequence s_ctrl0_wr; WR_IN && ADDR_IN == ASC_ADDR_CTRL0; endsequence
   sequence s_natural_end; BUSY_OUT && !WR_IN ##1 !BUSY_OUT; endsequence
   a_start_busy: assert property (s_ctrl0_wr ##0 (WR_DATA_IN[ASC_C0_START_BIT] && !BUSY_OUT)
      |=> BUSY_OUT) else $error("start ignored");
   a_busy_cause: assert property ($rose(BUSY_OUT) |-> $past(WR_IN && ADDR_IN == ASC_ADDR_CTRL0
      && WR_DATA_IN[ASC_C0_START_BIT])) else $error("busy without start");
   a_stop_now: assert property (s_ctrl0_wr ##0 !WR_DATA_IN[ASC_C0_START_BIT] |=> !BUSY_OUT)
      else $error("stop ignored");
   a_end_irq: assert property (s_natural_end |-> IRQ_OUT) else $error("no irq");
   a_irq_cause: assert property (IRQ_OUT |-> !BUSY_OUT && $past(BUSY_OUT, 2))
      else $error("irq without end");
   a_irq_pulse: assert property (IRQ_OUT |=> !IRQ_OUT) else $error("irq too long");
   a_irq_modes: assert property (IRQ_OUT |-> mode == ASC_MODE_ONESHOT
      || mode == ASC_MODE_SWEEP) else $error("irq in repeat mode");
   a_ladder_ctrl: assert property (WR_IN && ADDR_IN == ASC_ADDR_CTRL1 |=>
      LADDER_ON_OUT == $past(WR_DATA_IN[ASC_C1_VREF_BIT])) else $error("ladder");
   a_sec_range: assert property (SECONDARY_OUT |-> CHAN_OUT <= 3'h4)
      else $error("secondary above 4");
   a_sample_busy: assert property (SAMPLE_OUT |-> BUSY_OUT) else $error("idle sample");
   a_read_quiet: assert property (!$past(RD_IN) |-> RD_DATA_OUT == 8'h00)
      else $error("stray read data");
endmodule

// ---- verification/asc_analog_model.sv ----
// Purpose: Analog pins and comparator seen by the sequencer.
// Assumes: Comparator answers at once to the trial code.
// Notes:   Every pin carries a fixed distinct level.
`timescale 1ns/1ns
module asc_analog_model (
   input  wire logic [2:0] chan_in,
   input  wire logic       sec_in,
   input  wire logic [9:0] trial_in,
   output logic            cmp_out
);
   // Level of each pin, primary and secondary group
   function automatic logic [9:0] level(input logic [2:0] ch, input logic s);
      level = s ? 10'h3C6 - {1'b0, ch, 6'h00} : {ch, 7'h00} ^ 10'h0A5;
   endfunction
   // High while the selected input pin is below the trial level
   assign cmp_out = (level(chan_in, sec_in) < trial_in);
endmodule

// ---- verification/asc_sequencer_bench.sv ----
// Purpose: Self-checking bench of the converter sequencer.
// Assumes: Divide by 4 gives exact codes with the instant comparator.
// Notes:   Each scenario task judges its own results.
`timescale 1ns/1ns
module asc_sequencer_bench
   import asc_pkg::*;
;
   logic       clk, rst_n, wr, rd, cmp, sec, samp, ladder, busy, irq, sec_seen;
   logic [9:0] addr, trial;
   logic [7:0] wdata, rdata;
   logic [2:0] chan;
   logic [2:0] seq[$];
   int         mismatches = 0, n_tests = 0, n_irq = 0, n_samp = 0;
   asc_sequencer dut (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WR_DATA_IN(wdata),
      .WR_IN(wr), .RD_IN(rd), .COMPARE_IN(cmp), .RD_DATA_OUT(rdata), .CHAN_OUT(chan),
      .SECONDARY_OUT(sec), .SAMPLE_OUT(samp), .TRIAL_CODE_OUT(trial),
      .LADDER_ON_OUT(ladder), .BUSY_OUT(busy), .IRQ_OUT(irq));
   asc_analog_model ana (.chan_in(chan), .sec_in(sec), .trial_in(trial), .cmp_out(cmp));
   // Clock and interrupt pulse counter
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(negedge clk) if (irq === 1'b1) n_irq++;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   // Channel expected at position k of the visiting order
   function automatic logic [2:0] exp_chan(input logic [7:0] c0, input logic [1:0] g, int k);
      int e;
      e = g + 1;
      case (c0[5:3])
         ASC_MODE_SWEEP, ASC_MODE_RSWEEP0: exp_chan = 3'(k % (2 * e));
         ASC_MODE_RSWEEP1: exp_chan = 3'((k % (e + 1) < e) ? k % (e + 1)
                                         : e + (k / (e + 1)) % (8 - e));
         default: exp_chan = c0[2:0];
      endcase
   endfunction
   task automatic res_chk(input logic [2:0] ch, input logic s, input logic ten);
      logic [9:0] v;
      v = ana.level(ch, s);
      rd_chk(ASC_ADDR_RES_BASE + {6'h00, ch, 1'b0}, ten ? v[7:0] : v[9:2]);
      rd_chk(ASC_ADDR_RES_BASE + {6'h00, ch, 1'b1}, {6'h00, v[9:8]});
   endtask
   // One conversion run: natural end, or stop after stop_at cycles
   task automatic run(input logic [7:0] c0, c1, c2, input int stop_at, len, n_int);
      int n;
      int i0;
      wr_reg(ASC_ADDR_CTRL2, c2);
      wr_reg(ASC_ADDR_CTRL1, c1);
      #1;
      chk(ladder, c1[ASC_C1_VREF_BIT]);
      seq.delete();
      sec_seen = 1'b0;
      i0 = n_irq;
      n = 0;
      n_samp = 0;
      wr_reg(ASC_ADDR_CTRL0, c0 | 8'h40);
      #1;
      while (busy === 1'b1 && n < 4000 && (stop_at == 0 || n < stop_at)) begin
         if (seq.size() == 0 || seq[$] !== chan) seq.push_back(chan);
         sec_seen |= sec;
         if (samp === 1'b1) n_samp++;
         @(posedge clk);
         #1;
         n++;
      end
      if (stop_at != 0) begin
         if (stop_at > 300) res_chk(seq[0], 1'b0, 1'b1);
         wr_reg(ASC_ADDR_CTRL0, c0);
         #1;
         chk(busy, 1'b0);
      end else begin
         chk(busy, 1'b0);
         if (len != 0) chk(16'(n), 16'(len));
      end
      foreach (seq[i]) chk(seq[i], exp_chan(c0, c1[1:0], i));
      repeat (3) @(posedge clk);
      chk(16'(n_irq - i0), 16'(n_int));
      rd_chk(ASC_ADDR_CTRL0, c0);
   endtask
   task automatic t_reset_regs;
      rd_chk(ASC_ADDR_CTRL0, ASC_CTRL0_RST);
      rd_chk(ASC_ADDR_CTRL1, ASC_CTRL1_RST);
      rd_chk(ASC_ADDR_CTRL2, ASC_CTRL2_RST);
      rd_chk(10'h3D5, 8'h00);
      wr_reg(ASC_ADDR_CTRL2, 8'hFF);
      rd_chk(ASC_ADDR_CTRL2, 8'h01);
      chk(busy, 1'b0);
   endtask
   // Every divider, hold setting and resolution in one-shot mode
   task automatic t_timing;
      int f;
      int ln;
      for (int d = 0; d < 4; d++) begin
         f = (d == 0) ? 1 : (d == 1) ? 2 : 4;
         for (int h = 0; h < 2; h++) begin
            for (int r = 1; r >= 0; r--) begin
               ln = h ? (r ? 33 : 28) : (r ? 59 : 49);
               run({2'b00, ASC_MODE_ONESHOT, 3'(2 * d + h)}, {3'b001, 2'(d), 1'(r), 2'b00},
                   8'(h), 0, ln * f, 1);
               chk(16'(n_samp), 16'((ln - (r ? ASC_TRIALS_10 : ASC_TRIALS_8)) * f));
               if (f == 4) res_chk(3'(2 * d + h), 1'b0, 1'(r));
            end
         end
      end
   endtask
   task automatic t_sweeps;
      for (int g = 0; g < 4; g++) begin
         run({2'b00, ASC_MODE_SWEEP, 3'h0}, {3'b001, 2'h3, 1'b1, 2'(g)}, 8'h01, 0, 0, 1);
         for (int c = 0; c < 2 * g + 2; c++) res_chk(3'(c), 1'b0, 1'b1);
         chk(16'(seq.size()), 16'(2 * g + 2));
      end
   endtask
   task automatic t_repeats;
      run({2'b00, ASC_MODE_REPEAT, 3'h6}, 8'h3C, 8'h01, 700, 0, 0);
      run({2'b00, ASC_MODE_RSWEEP0, 3'h0}, 8'h3D, 8'h01, 1400, 0, 0);
      run({2'b00, ASC_MODE_RSWEEP1, 3'h0}, 8'h3C, 8'h01, 1400, 0, 0);
      run({2'b00, ASC_MODE_ONESHOT, 3'h1}, 8'h3C, 8'h01, 20, 0, 0);
   endtask
   task automatic t_secondary;
      run({2'b00, ASC_MODE_ONESHOT, 3'h2}, 8'h7C, 8'h01, 0, 132, 1);
      chk(sec_seen, 1'b1);
      res_chk(3'h2, 1'b1, 1'b1);
   endtask
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_n = 1'b0;
      addr  = 10'h000;
      wdata = 8'h00;
      wr    = 1'b0;
      rd    = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_regs;
      t_timing;
      t_sweeps;
      t_repeats;
      t_secondary;
      give_verdict;
   end
   // Watchdog against a hung conversion
   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      give_verdict;
   end
endmodule
bind asc_sequencer asc_sequencer_asserts u_chk (.CLK_IN, .RST_N_IN, .ADDR_IN, .WR_DATA_IN,
   .WR_IN, .RD_IN, .COMPARE_IN, .RD_DATA_OUT, .CHAN_OUT, .SECONDARY_OUT, .SAMPLE_OUT,
   .TRIAL_CODE_OUT, .LADDER_ON_OUT, .BUSY_OUT, .IRQ_OUT);
